// file: verilog/brs_pkg.sv
// Contract
// - Internal strap low: enable core regulator after release.
// - PLL enabled only after core supply is good.
// - Clock straps 00: default parameters, 12 MHz reference.
// - Boot ready: push event, pull host interrupt low.
// - Auto boot strap starts fetching from serial flash.
// - First host port to start becomes boot master.
// - Two host port clock cycles select SPI, else I2C.
// - Reset low: stay in reset, tristate outputs.
// - Both audio ports: master/slave, PCM/GCI/I2S selectable.
// - Port A bit clock: bit-rate output master, input slave.
// - Port A powers up as I2S slave, clock input.
// - Reset low over 10 us shuts core supply off.
// - Boot strap 0 host boot, 1 auto boot.
// - Clock straps: 00 12MHz, 01 8kHz, 10 16kHz, 11 reserved.
package brs_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MODE_TIME_US = 10;
  localparam int RESET_MODE_CYCLES = (RESET_MODE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] RMODE_LAST = 11'(RESET_MODE_CYCLES - 1);

  localparam logic [1:0] CLKSEL_XTAL_12M = 2'h0;
  localparam logic [1:0] CLKSEL_FS_8K = 2'h1;
  localparam logic [1:0] CLKSEL_FS_16K = 2'h2;
  localparam logic [1:0] CLKSEL_RESERVED = 2'h3;

  localparam logic BOOT_HOST = 1'b0;
  localparam logic BOOT_AUTO = 1'b1;
  localparam logic SUPPLY_INTERNAL = 1'b0;

  localparam logic [1:0] FMT_PCM = 2'h0;
  localparam logic [1:0] FMT_GCI = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] PORT_FMT_RST = FMT_I2S;
  localparam logic PORT_MASTER_RST = 1'b0;
  localparam logic SUPPLY_ON_RST = 1'b0;

  localparam logic [7:0] EVT_NONE = 8'h00;
  localparam logic [7:0] EVT_BOOT_READY = 8'h01;
  localparam logic [7:0] EVT_BAD_CLKSEL = 8'h02;

  localparam logic [1:0] BM_NONE = 2'h0;
  localparam logic [1:0] BM_SPI = 2'h1;
  localparam logic [1:0] BM_I2C = 2'h2;

  localparam logic [1:0] SPI_DETECT_EDGES = 2'h2;

  typedef enum logic [7:0] {
    ST_RESET  = 8'h01,
    ST_SUPPLY = 8'h02,
    ST_PLL    = 8'h04,
    ST_NOTIFY = 8'h08,
    ST_FLASH  = 8'h10,
    ST_HOST   = 8'h20,
    ST_RUN    = 8'h40,
    ST_HALT   = 8'h80
  } brs_state_t;

endpackage

// file: verilog/brs_hport_detect.sv
`timescale 1ns/1ps
module brs_hport_detect (
  input wire logic host_port_clock,
  input wire logic arm,
  output logic edge_toggle
);
  import brs_pkg::*;

  typedef struct packed {
    logic [1:0] arm_sync;
    logic toggle;
  } brs_link_regs_t;

  brs_link_regs_t q;
  brs_link_regs_t d;

  // No reset reaches this domain: any level but a synced high arm clears it on the first edges
  // One toggle per rising edge crosses as a single bit, so no edge waits on a handshake
  always_comb
  begin
    d = q;
    d.arm_sync = {q.arm_sync[0], arm};
    if (q.arm_sync[1])
    begin
      d.toggle = !q.toggle;
    end
    else
    begin
      d.toggle = 1'b0;
    end
  end

  always_ff @(posedge host_port_clock)
  begin
    q <= d;
  end

  assign edge_toggle = q.toggle;

endmodule

// file: verilog/brs_sequencer.sv
`timescale 1ns/1ps
module brs_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_n_pin,
  input wire logic ref_clk_valid,
  input wire logic supply_source_strap,
  input wire logic [1:0] clock_select_strap,
  input wire logic boot_source_strap,
  input wire logic core_supply_good,
  input wire logic pll_lock,
  input wire logic host_port_clock,
  input wire logic host_spi_start,
  input wire logic host_i2c_start,
  input wire logic host_int_ack,
  input wire logic port_cfg_load,
  input wire logic port_a_master_cfg,
  input wire logic [1:0] port_a_format_cfg,
  input wire logic [7:0] port_a_half_period,
  input wire logic port_b_master_cfg,
  input wire logic [1:0] port_b_format_cfg,
  output logic core_supply_control,
  output logic pll_enable,
  output logic [1:0] pll_ref_sel,
  output logic default_params,
  output logic event_push,
  output logic [7:0] event_code,
  output logic host_interrupt_n_o,
  output logic host_interrupt_n_oe,
  output logic flash_boot_start,
  output logic [1:0] boot_master,
  output logic host_port_is_spi,
  output logic port_a_bit_clock_o,
  output logic port_a_bit_clock_oe,
  output logic port_a_master,
  output logic [1:0] port_a_format,
  output logic port_b_master,
  output logic [1:0] port_b_format,
  output brs_pkg::brs_state_t boot_state
);
  import brs_pkg::*;

  typedef struct packed {
    brs_state_t st;
    logic [1:0] rst_sync;
    logic [1:0] ref_sync;
    logic [1:0] sup_sync;
    logic [1:0] lock_sync;
    logic [1:0] tgl_sync;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [10:0] low_cnt;
    logic rmode;
    logic supply_on;
    logic [1:0] clk_sel;
    logic boot_src;
    logic supply_src;
    logic int_act;
    logic evt_push;
    logic [7:0] evt_code;
    logic flash_start;
    logic [1:0] boot_master;
    logic is_spi;
    logic pa_master;
    logic [1:0] pa_fmt;
    logic pb_master;
    logic [1:0] pb_fmt;
    logic [7:0] div_cnt;
    logic pa_clk;
    logic arm;
    logic tgl_last;
    logic [1:0] hp_edges;
  } brs_regs_t;

  brs_regs_t q;
  brs_regs_t d;
  logic pin_ok;
  logic ref_ok;
  logic sup_ok;
  logic lock_ok;
  logic in_reset;
  logic link_toggle;

  brs_hport_detect u_hport_detect (
    .host_port_clock(host_port_clock),
    .arm(q.arm),
    .edge_toggle(link_toggle)
  );

  assign pin_ok = q.rst_sync[1];
  assign ref_ok = q.ref_sync[1];
  assign sup_ok = q.sup_sync[1];
  assign lock_ok = q.lock_sync[1];
  // Without a valid reference the sequence never leaves reset
  assign in_reset = !pin_ok || !ref_ok;

  always_comb
  begin
    d = q;
    d.evt_push = 1'b0;
    d.flash_start = 1'b0;
    d.rst_sync = {q.rst_sync[0], reset_n_pin};
    d.ref_sync = {q.ref_sync[0], ref_clk_valid};
    d.sup_sync = {q.sup_sync[0], core_supply_good};
    d.lock_sync = {q.lock_sync[0], pll_lock};
    d.tgl_sync = {q.tgl_sync[0], link_toggle};
    d.tgl_last = q.tgl_sync[1];
    d.arm = 1'b1;
    d.strap_s1 = {supply_source_strap, boot_source_strap, clock_select_strap};
    d.strap_s2 = q.strap_s1;

    // Short glitches on the pin reset the logic but keep the core powered
    if (!pin_ok)
    begin
      if (q.low_cnt != RMODE_LAST)
      begin
        d.low_cnt = q.low_cnt + 11'h001;
      end
      else
      begin
        d.rmode = 1'b1;
      end
    end
    else
    begin
      d.low_cnt = 11'h000;
      d.rmode = 1'b0;
    end
    if (d.rmode)
    begin
      d.supply_on = 1'b0;
    end

    // Ack clears first so a set in the same cycle wins
    if (host_int_ack)
    begin
      d.int_act = 1'b0;
    end

    unique case (q.st)
      ST_RESET:
      begin
        if (!in_reset)
        begin
          d.clk_sel = q.strap_s2[1:0];
          d.boot_src = q.strap_s2[2];
          d.supply_src = q.strap_s2[3];
          // The external option also uses this output as its enable
          d.supply_on = 1'b1;
          d.st = ST_SUPPLY;
        end
      end
      ST_SUPPLY:
      begin
        if (sup_ok)
        begin
          d.st = ST_PLL;
        end
      end
      ST_PLL:
      begin
        if (q.clk_sel == CLKSEL_RESERVED)
        begin
          d.evt_push = 1'b1;
          d.evt_code = EVT_BAD_CLKSEL;
          d.st = ST_HALT;
        end
        else if (lock_ok)
        begin
          d.st = ST_NOTIFY;
        end
      end
      ST_NOTIFY:
      begin
        d.evt_push = 1'b1;
        d.evt_code = EVT_BOOT_READY;
        d.int_act = 1'b1;
        if (q.boot_src == BOOT_AUTO)
        begin
          d.st = ST_FLASH;
        end
        else
        begin
          d.hp_edges = 2'h0;
          d.st = ST_HOST;
        end
      end
      ST_FLASH:
      begin
        d.flash_start = 1'b1;
        d.st = ST_RUN;
      end
      ST_HOST:
      begin
        // One toggle change per rising host clock edge; that clock must stay below half of clk_sys
        if ((q.tgl_sync[1] != q.tgl_last) && (q.hp_edges != SPI_DETECT_EDGES))
        begin
          d.hp_edges = q.hp_edges + 2'h1;
        end
        d.is_spi = (q.hp_edges == SPI_DETECT_EDGES);
        if (host_spi_start || host_i2c_start)
        begin
          // A tie goes to the protocol the port detector chose
          if (host_spi_start && (!host_i2c_start || (q.hp_edges == SPI_DETECT_EDGES)))
          begin
            d.boot_master = BM_SPI;
          end
          else
          begin
            d.boot_master = BM_I2C;
          end
          d.st = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (port_cfg_load)
        begin
          d.pa_master = port_a_master_cfg;
          d.pa_fmt = port_a_format_cfg;
          d.pb_master = port_b_master_cfg;
          d.pb_fmt = port_b_format_cfg;
        end
      end
      ST_HALT:
      begin
        d.st = ST_HALT;
      end
    endcase

    // Master divider: one half period of the bit clock per count wrap
    if (q.pa_master)
    begin
      if (q.div_cnt >= port_a_half_period)
      begin
        d.div_cnt = 8'h00;
        d.pa_clk = !q.pa_clk;
      end
      else
      begin
        d.div_cnt = q.div_cnt + 8'h01;
      end
    end
    else
    begin
      d.div_cnt = 8'h00;
      d.pa_clk = 1'b0;
    end

    if (in_reset)
    begin
      d.st = ST_RESET;
      d.int_act = 1'b0;
      d.evt_push = 1'b0;
      d.flash_start = 1'b0;
      d.boot_master = BM_NONE;
      d.is_spi = 1'b0;
      d.hp_edges = 2'h0;
      d.pa_master = PORT_MASTER_RST;
      d.pa_fmt = PORT_FMT_RST;
      d.pb_master = PORT_MASTER_RST;
      d.pb_fmt = PORT_FMT_RST;
      d.div_cnt = 8'h00;
      d.pa_clk = 1'b0;
    end

    if (rst)
    begin
      d = '0;
      d.st = ST_RESET;
      d.supply_on = SUPPLY_ON_RST;
      d.clk_sel = CLKSEL_XTAL_12M;
      d.boot_src = BOOT_HOST;
      d.supply_src = SUPPLY_INTERNAL;
      d.evt_code = EVT_NONE;
      d.boot_master = BM_NONE;
      d.pa_master = PORT_MASTER_RST;
      d.pa_fmt = PORT_FMT_RST;
      d.pb_master = PORT_MASTER_RST;
      d.pb_fmt = PORT_FMT_RST;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    q <= d;
  end

  assign core_supply_control = q.supply_on;
  assign pll_enable = (q.st == ST_PLL) || (q.st == ST_NOTIFY) || (q.st == ST_FLASH) ||
                      (q.st == ST_HOST) || (q.st == ST_RUN);
  assign pll_ref_sel = q.clk_sel;
  assign default_params = pll_enable && (q.clk_sel == CLKSEL_XTAL_12M);
  assign event_push = q.evt_push;
  assign event_code = q.evt_code;
  assign host_interrupt_n_o = 1'b0;
  assign host_interrupt_n_oe = q.int_act;
  assign flash_boot_start = q.flash_start;
  assign boot_master = q.boot_master;
  assign host_port_is_spi = q.is_spi;
  assign port_a_bit_clock_o = q.pa_clk;
  assign port_a_bit_clock_oe = q.pa_master;
  assign port_a_master = q.pa_master;
  assign port_a_format = q.pa_fmt;
  assign port_b_master = q.pb_master;
  assign port_b_format = q.pb_fmt;
  assign boot_state = q.st;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_notify_enter;
    (q.st == ST_NOTIFY) && !in_reset;
  endsequence

  sequence s_ready_signalled;
    event_push && (event_code == EVT_BOOT_READY) && host_interrupt_n_oe && !host_interrupt_n_o;
  endsequence

  a_supply_on_release: assert property (
    (q.st == ST_RESET && !in_reset) |=> core_supply_control && (q.st == ST_SUPPLY))
    else $error("core supply not enabled after reset release");

  a_pll_after_supply: assert property (
    $rose(pll_enable) |-> $past(sup_ok) && core_supply_control)
    else $error("pll enabled before core supply was good");

  a_default_xtal: assert property (
    (q.st == ST_SUPPLY && sup_ok && !in_reset && pll_ref_sel == CLKSEL_XTAL_12M) |=> pll_enable && default_params)
    else $error("default parameters missing for crystal reference");

  a_boot_ready_event: assert property (
    s_notify_enter |=> s_ready_signalled ##1 (host_interrupt_n_oe || $past(host_int_ack) || $past(in_reset)))
    else $error("boot ready event or interrupt missing");

  a_auto_flash_start: assert property (
    (s_notify_enter and (q.boot_src == BOOT_AUTO)) |=> ##1 (flash_boot_start || in_reset))
    else $error("flash fetch not started in auto boot");

  a_first_master: assert property (
    (q.st == ST_HOST && !in_reset && host_spi_start && !host_i2c_start) |=> boot_master == BM_SPI)
    else $error("spi start did not become boot master");

  a_spi_select: assert property (
    (q.st == ST_HOST && !in_reset) |=> host_port_is_spi == $past(q.hp_edges == SPI_DETECT_EDGES))
    else $error("host port protocol does not follow detector");

  a_reset_tristate: assert property (
    !pin_ok |=> !host_interrupt_n_oe && !port_a_bit_clock_oe && !flash_boot_start)
    else $error("output driven while reset pin low");

  a_port_a_default: assert property (
    (q.st == ST_RESET) |-> !port_a_bit_clock_oe && (port_a_format == FMT_I2S) && !port_a_master)
    else $error("port a not i2s slave after reset");

  a_reset_mode_off: assert property (
    (!pin_ok && q.low_cnt == RMODE_LAST) |=> !core_supply_control)
    else $error("core supply still on in reset mode");

  a_straps_held: assert property (
    (q.st != ST_RESET && $past(q.st) != ST_RESET) |-> $stable(pll_ref_sel))
    else $error("clock select changed during boot");

endmodule

// file: tb/brs_host_model.sv
`timescale 1ns/1ps
module brs_host_model (
  input wire logic clk_sys,
  input wire logic host_interrupt_n_o,
  input wire logic host_interrupt_n_oe,
  output logic host_port_clock,
  output logic host_spi_start,
  output logic host_i2c_start,
  output logic host_int_ack
);
  logic ack_en;
  logic irq_pin;
  // Pulled up on the board, so a released pin reads high
  assign irq_pin = host_interrupt_n_oe ? host_interrupt_n_o : 1'b1;
  initial
  begin
    host_port_clock = 1'b0;
    host_spi_start = 1'b0;
    host_i2c_start = 1'b0;
    ack_en = 1'b0;
  end
  // Link clock idles low and only runs inside a burst
  task automatic burst(input int n);
    #5;
    repeat (n)
    begin
      #24 host_port_clock = 1'b1;
      #24 host_port_clock = 1'b0;
    end
  endtask
  task automatic start_load(input logic spi);
    @(posedge clk_sys);
    host_spi_start <= spi;
    host_i2c_start <= !spi;
    @(posedge clk_sys);
    host_spi_start <= 1'b0;
    host_i2c_start <= 1'b0;
  endtask
  initial
    host_int_ack = 1'b0;
  always @(posedge clk_sys)
    host_int_ack <= ack_en && !irq_pin && !host_int_ack;
endmodule

// file: tb/brs_sequencer_tb_top.sv
`timescale 1ns/1ps
module brs_sequencer_tb_top;
  import brs_pkg::*;
  logic clk_sys, rst, reset_n_pin, ref_clk_valid, supply_source_strap, boot_source_strap;
  logic core_supply_good, pll_lock, port_cfg_load, port_a_master_cfg, port_b_master_cfg;
  logic [1:0] clock_select_strap, port_a_format_cfg, port_b_format_cfg;
  logic [7:0] port_a_half_period;
  logic host_port_clock, host_spi_start, host_i2c_start, host_int_ack;
  logic core_supply_control, pll_enable, default_params, event_push, host_interrupt_n_o;
  logic host_interrupt_n_oe, flash_boot_start, host_port_is_spi, port_a_bit_clock_o;
  logic port_a_bit_clock_oe, port_a_master, port_b_master;
  logic [1:0] pll_ref_sel, boot_master, port_a_format, port_b_format;
  logic [7:0] event_code;
  brs_state_t boot_state;
  logic port_a_pin;
  int num_errors, checks_done, seed, exp_flash, flash_seen;
  logic [7:0] exp_ev[$];

  brs_sequencer dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .reset_n_pin(reset_n_pin),
    .ref_clk_valid(ref_clk_valid),
    .supply_source_strap(supply_source_strap),
    .clock_select_strap(clock_select_strap),
    .boot_source_strap(boot_source_strap),
    .core_supply_good(core_supply_good),
    .pll_lock(pll_lock),
    .host_port_clock(host_port_clock),
    .host_spi_start(host_spi_start),
    .host_i2c_start(host_i2c_start),
    .host_int_ack(host_int_ack),
    .port_cfg_load(port_cfg_load),
    .port_a_master_cfg(port_a_master_cfg),
    .port_a_format_cfg(port_a_format_cfg),
    .port_a_half_period(port_a_half_period),
    .port_b_master_cfg(port_b_master_cfg),
    .port_b_format_cfg(port_b_format_cfg),
    .core_supply_control(core_supply_control),
    .pll_enable(pll_enable),
    .pll_ref_sel(pll_ref_sel),
    .default_params(default_params),
    .event_push(event_push),
    .event_code(event_code),
    .host_interrupt_n_o(host_interrupt_n_o),
    .host_interrupt_n_oe(host_interrupt_n_oe),
    .flash_boot_start(flash_boot_start),
    .boot_master(boot_master),
    .host_port_is_spi(host_port_is_spi),
    .port_a_bit_clock_o(port_a_bit_clock_o),
    .port_a_bit_clock_oe(port_a_bit_clock_oe),
    .port_a_master(port_a_master),
    .port_a_format(port_a_format),
    .port_b_master(port_b_master),
    .port_b_format(port_b_format),
    .boot_state(boot_state)
  );
  brs_host_model host (
    .clk_sys(clk_sys),
    .host_interrupt_n_o(host_interrupt_n_o),
    .host_interrupt_n_oe(host_interrupt_n_oe),
    .host_port_clock(host_port_clock),
    .host_spi_start(host_spi_start),
    .host_i2c_start(host_i2c_start),
    .host_int_ack(host_int_ack)
  );
  // Pull-down holds the bit clock low when nobody drives it
  assign port_a_pin = port_a_bit_clock_oe ? port_a_bit_clock_o : 1'b0;

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task wait_st(input brs_state_t s);
    int n;
    n = 0;
    while (boot_state !== s && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("state", s, boot_state);
  endtask

  always @(negedge clk_sys)
  begin
    if (event_push === 1'b1)
      chk("event", exp_ev.size() ? exp_ev.pop_front() : 8'hff, event_code);
    if (flash_boot_start === 1'b1)
      flash_seen++;
  end

  task boot(input logic [1:0] cs, input logic bs);
    exp_ev.push_back(cs == CLKSEL_RESERVED ? EVT_BAD_CLKSEL : EVT_BOOT_READY);
    @(posedge clk_sys);
    reset_n_pin <= 1'b0;
    ref_clk_valid <= 1'b0;
    core_supply_good <= 1'b0;
    pll_lock <= 1'b0;
    clock_select_strap <= cs;
    boot_source_strap <= bs;
    supply_source_strap <= SUPPLY_INTERNAL;
    tick(8);
    chk("oe_rst", 8'h00, {host_interrupt_n_oe, port_a_bit_clock_oe});
    wait_st(ST_RESET);
    host.burst(3);
    @(posedge clk_sys) reset_n_pin <= 1'b1;
    tick(20);
    chk("no_ref", ST_RESET, boot_state);
    @(posedge clk_sys) ref_clk_valid <= 1'b1;
    wait_st(ST_SUPPLY);
    chk("supply", 1, core_supply_control);
    @(posedge clk_sys) clock_select_strap <= ~cs;
    boot_source_strap <= ~bs;
    tick(20);
    chk("pll_early", 0, pll_enable);
    @(posedge clk_sys) core_supply_good <= 1'b1;
    if (cs == CLKSEL_RESERVED)
    begin
      wait_st(ST_HALT);
      tick(3);
      chk("pll_halt", 0, pll_enable);
      return;
    end
    wait_st(ST_PLL);
    chk("pll_en", 1, pll_enable);
    chk("defaults", cs == CLKSEL_XTAL_12M, default_params);
    chk("ref_sel", cs, pll_ref_sel);
    @(posedge clk_sys) pll_lock <= 1'b1;
    wait_st(bs ? ST_FLASH : ST_HOST);
    chk("irq", 8'h01, {host_interrupt_n_o, host_interrupt_n_oe});
    if (bs)
      exp_flash++;
    else
    begin
      host.burst(cs == CLKSEL_FS_8K ? 2 : 1);
      tick(10);
      chk("is_spi", cs == CLKSEL_FS_8K, host_port_is_spi);
      host.start_load(cs == CLKSEL_FS_8K);
      host.start_load(cs != CLKSEL_FS_8K);
    end
    wait_st(ST_RUN);
    chk("master", bs ? BM_NONE : (cs == CLKSEL_FS_8K ? BM_SPI : BM_I2C), boot_master);
    chk("ref_hold", cs, pll_ref_sel);
    tick(20);
    chk("irq_hold", 1, host_interrupt_n_oe);
    host.ack_en = 1'b1;
    tick(6);
    chk("irq_ack", 0, host_interrupt_n_oe);
    host.ack_en = 1'b0;
  endtask

  task ports;
    logic [7:0] half;
    logic p;
    int n;
    for (int i = 0; i < 3; i++)
    begin
      half = 8'($random(seed)) & 8'h07;
      @(posedge clk_sys);
      port_a_master_cfg <= (i != 1);
      port_a_format_cfg <= 2'(i);
      port_b_master_cfg <= i[0];
      port_b_format_cfg <= 2'(2 - i);
      port_a_half_period <= half;
      port_cfg_load <= 1'b1;
      @(posedge clk_sys) port_cfg_load <= 1'b0;
      tick(3);
      chk("cfg", {2'(i), 1'(i != 1), 2'(2 - i), 1'(i % 2)},
        {port_a_format, port_a_master, port_b_format, port_b_master});
      chk("a_oe", i != 1, port_a_bit_clock_oe);
      if (i == 1)
        chk("a_pin", 0, port_a_pin);
      else
      begin
        for (int j = 0; j < 2; j++)
        begin
          p = port_a_pin;
          n = 0;
          while (port_a_pin === p && n < 300)
          begin
            tick(1);
            n++;
          end
        end
        chk("a_half", half + 8'h01, 8'(n));
      end
    end
  endtask

  initial
  begin
    seed = 7;
    {rst, reset_n_pin, ref_clk_valid, supply_source_strap, boot_source_strap} = 5'h10;
    {core_supply_good, pll_lock, port_cfg_load, port_a_master_cfg, port_b_master_cfg} = 5'h00;
    {clock_select_strap, port_a_format_cfg, port_b_format_cfg} = 6'h00;
    port_a_half_period = 8'h00;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    tick(2);
    chk("por", {PORT_FMT_RST, 2'h0}, {port_a_format, port_a_master, port_a_bit_clock_oe});
    boot(CLKSEL_XTAL_12M, BOOT_AUTO);
    ports();
    for (int k = 1; k < 4; k++)
      boot(2'(k), BOOT_HOST);
    @(posedge clk_sys) reset_n_pin <= 1'b0;
    tick(100);
    chk("short_rst", 1, core_supply_control);
    tick(1200);
    chk("long_rst", 0, core_supply_control);
    chk("flash", 8'(exp_flash), 8'(flash_seen));
    chk("ev_left", 0, 8'(exp_ev.size()));
    close_out();
  end

  initial
  begin
    #400000;
    num_errors++;
    close_out();
  end
endmodule
